// [rphc_pkg.sv]
package rphc_pkg;
    localparam int          CLK_HZ            = 50_000_000;
    localparam int          FILTER_CLKS       = 4;
    localparam int          LATCH_CLKS        = 5;
    localparam int          HOLD_CLKS         = 18;
    localparam int          FETCH_DELAY_CLKS  = 5;
    localparam int          POR_TIME_US       = 5000;
    localparam int          RC_HZ             = 1_000_000;
    localparam int          POR_RC_TICKS      = POR_TIME_US * (RC_HZ / 1_000_000);
    localparam int          SLEEP_BYPASS_BIT  = 5;
    localparam logic [15:0] RESTART_VECTOR    = 16'h000C;
    localparam logic [7:0]  NOP_OPCODE        = 8'hFF;

    typedef enum logic [1:0] {
        RPHC_RUN     = 2'b00,
        RPHC_QUALIFY = 2'b01,
        RPHC_HOLD    = 2'b10,
        RPHC_RELEASE = 2'b11
    } rphc_state_t;

    // Reset and restart signals handed to the processor core.
    typedef struct packed {
        logic        core_reset;
        logic        fetch_start;
        logic [15:0] fetch_addr;
    } rphc_core_t;
endpackage

// [rphc_por_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// One-shot power-on timer counted on ticks from the dedicated RC oscillator.
module rphc_por_timer
    import rphc_pkg::*;
#(
    parameter int TICKS = POR_RC_TICKS
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic rc_tick_in,
    input  wire logic trigger_in,
    output logic      active_out
);
    logic [15:0] count;

    // Retrigger restarts the full interval; the count advances only on RC ticks.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count      <= 16'h0000;
            active_out <= 1'b1;
        end else if (trigger_in) begin
            count      <= 16'h0000;
            active_out <= 1'b1;
        end else if (active_out && rc_tick_in) begin
            count      <= count + 16'h0001;
            active_out <= (count + 16'h0001) < TICKS[15:0];
        end
    end
endmodule // rphc_por_timer
`default_nettype wire

// [rphc_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Reset filter, reset stretcher, power-on pin drive and suspend control.
module rphc_top
    import rphc_pkg::*;
#(
    parameter int POR_TICKS = POR_RC_TICKS
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       reset_pin_in,
    input  wire logic       rc_tick_in,
    input  wire logic       supply_good_in,
    input  wire logic       watchdog_timeout_source_in,
    input  wire logic       sleep_recovery_in,
    input  wire logic [7:0] sleep_ctrl_in,
    input  wire logic       suspend_req_in,
    input  wire logic       irq_serviced_in,
    output logic            reset_pin_out,
    output logic            reset_pin_oe_out,
    output logic            data_strobe_n_out,
    output logic            address_strobe_n_out,
    output logic            core_reset_out,
    output logic            fetch_start_out,
    output logic [15:0]     fetch_addr_out,
    output logic            cpu_clock_suspend_mode_out
);
    rphc_state_t state;
    rphc_state_t next_state;
    logic        pin_sync1;
    logic        pin_sync2;
    logic        supply_q;
    logic [4:0]  count;
    logic [4:0]  next_count;
    logic        por_active;
    logic        por_trigger;
    rphc_core_t  next_core;

    // Hold and release both count as reset for the core; one decode serves state and next state.
    function automatic logic is_reset_phase(input rphc_state_t s);
        return (s == RPHC_HOLD) || (s == RPHC_RELEASE);
    endfunction

    // Two-stage synchroniser on the reset pin; only the second stage is used.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_sync1 <= 1'b1;
            pin_sync2 <= 1'b1;
            supply_q  <= 1'b0;
        end else begin
            pin_sync1 <= reset_pin_in;
            pin_sync2 <= pin_sync1;
            supply_q  <= supply_good_in;
        end
    end

    wire pin_low   = ~pin_sync2;
    wire supply_up = supply_good_in & ~supply_q;
    wire sleep_por = sleep_recovery_in & ~sleep_ctrl_in[SLEEP_BYPASS_BIT];

    // Power-on timer triggers; bit D5 set lets sleep recovery skip the delay.
    assign por_trigger = supply_up | watchdog_timeout_source_in | sleep_por;

    rphc_por_timer #(
        .TICKS(POR_TICKS)
    ) u_por (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .rc_tick_in(rc_tick_in),
        .trigger_in(por_trigger),
        .active_out(por_active)
    );

    // Any internal source forces the hold state directly, skipping the pin filter.
    wire internal_src = por_active | sleep_recovery_in;

    // Sequencer: qualify, latch on the ninth low clock, hold, then delay the fetch.
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            RPHC_RUN: begin
                next_count = 5'd0;
                if (internal_src) begin
                    next_state = RPHC_HOLD;
                end else if (pin_low) begin
                    next_state = RPHC_QUALIFY;
                    next_count = 5'd1;
                end
            end
            RPHC_QUALIFY: begin
                if (internal_src) begin
                    next_state = RPHC_HOLD;
                    next_count = 5'd0;
                end else if (!pin_low) begin
                    next_state = RPHC_RUN;
                    next_count = 5'd0;
                end else if (count == 5'(FILTER_CLKS + LATCH_CLKS - 1)) begin
                    next_state = RPHC_HOLD;
                    next_count = 5'd0;
                end else begin
                    next_count = count + 5'd1;
                end
            end
            RPHC_HOLD: begin
                if (count != 5'(HOLD_CLKS)) begin
                    next_count = count + 5'd1;
                end
                if (count >= 5'(HOLD_CLKS - 1) && !pin_low && !internal_src) begin
                    next_state = RPHC_RELEASE;
                    next_count = 5'd0;
                end
            end
            default: begin
                if (internal_src || pin_low) begin
                    next_state = RPHC_HOLD;
                    next_count = 5'd0;
                end else if (count == 5'(FETCH_DELAY_CLKS - 1)) begin
                    next_state = RPHC_RUN;
                end else begin
                    next_count = count + 5'd1;
                end
            end
        endcase
    end

    // The core sees reset in both phases; the fetch starts on the clock that release ends.
    wire next_in_reset = is_reset_phase(next_state);
    wire next_fetch    = (state == RPHC_RELEASE) && (next_state == RPHC_RUN);
    wire in_reset      = is_reset_phase(state);

    // One assignment fills the whole carrier, so the struct has a single driver.
    assign next_core = '{core_reset: next_in_reset, fetch_start: next_fetch, fetch_addr: RESTART_VECTOR};

    // State and registered outputs; every output comes from a flip-flop.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state                <= RPHC_HOLD;
            count                <= 5'd0;
            core_reset_out       <= 1'b1;
            fetch_start_out      <= 1'b0;
            fetch_addr_out       <= 16'h0000;
        end else begin
            state                <= next_state;
            count                <= next_count;
            core_reset_out       <= next_core.core_reset;
            fetch_start_out      <= next_core.fetch_start;
            fetch_addr_out       <= next_core.fetch_start ? next_core.fetch_addr : fetch_addr_out;
        end
    end

    // Strobes: data strobe held low, address strobe flips every clock during reset.
    // One flip per clock gives the fastest toggle this single clock can make.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_strobe_n_out    <= 1'b0;
            address_strobe_n_out <= 1'b1;
        end else begin
            data_strobe_n_out    <= ~next_core.core_reset;
            address_strobe_n_out <= next_core.core_reset ? ~address_strobe_n_out : 1'b1;
        end
    end

    // Open-drain reset pin: only ever pulled low, released once the timer ends.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reset_pin_out    <= 1'b0;
            reset_pin_oe_out <= 1'b1;
        end else begin
            reset_pin_out    <= 1'b0;
            reset_pin_oe_out <= por_active;
        end
    end

    // Suspend stops the core clock until an enabled interrupt is serviced.
    // The pipeline flush before suspend is left to software.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cpu_clock_suspend_mode_out <= 1'b0;
        end else if (in_reset || irq_serviced_in) begin
            cpu_clock_suspend_mode_out <= 1'b0;
        end else if (suspend_req_in) begin
            cpu_clock_suspend_mode_out <= 1'b1;
        end
    end

    property p_short_pulse_ignored;
        @(posedge clk_in) disable iff (rst_in)
        (state == RPHC_RUN && !internal_src && pin_low) ##1 (!pin_low && !internal_src) ##1 !internal_src
            |-> !core_reset_out ##1 !core_reset_out;
    endproperty
    a_short_pulse_ignored: assert property (p_short_pulse_ignored) else $error("short reset pulse caused reset");

    property p_latch_fifth;
        @(posedge clk_in) disable iff (rst_in)
        ($rose(state == RPHC_QUALIFY) && pin_low && !internal_src) ##1 (pin_low && !internal_src) [*7]
            |-> ##1 state == RPHC_HOLD;
    endproperty
    a_latch_fifth: assert property (p_latch_fifth) else $error("reset not latched after qualification");

    property p_hold_min;
        @(posedge clk_in) disable iff (rst_in)
        $rose(state == RPHC_HOLD) |-> core_reset_out [*8];
    endproperty
    a_hold_min: assert property (p_hold_min) else $error("internal reset released early");

    property p_strobes;
        @(posedge clk_in) disable iff (rst_in)
        core_reset_out && $past(core_reset_out) && !$past(rst_in)
            |-> !data_strobe_n_out && address_strobe_n_out != $past(address_strobe_n_out);
    endproperty
    a_strobes: assert property (p_strobes) else $error("strobes wrong during reset");

    property p_fetch_delay;
        @(posedge clk_in) disable iff (rst_in)
        $fell(core_reset_out) |-> fetch_start_out && fetch_addr_out == RESTART_VECTOR;
    endproperty
    a_fetch_delay: assert property (p_fetch_delay) else $error("fetch not started at restart vector");

    property p_pin_drive;
        @(posedge clk_in) disable iff (rst_in)
        por_active |=> reset_pin_oe_out && !reset_pin_out;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("reset pin not pulled low");

    property p_pin_release;
        @(posedge clk_in) disable iff (rst_in)
        !por_active |=> !reset_pin_oe_out;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("reset pin still driven");

    property p_wdt_trigger;
        @(posedge clk_in) disable iff (rst_in)
        watchdog_timeout_source_in |=> por_active ##1 core_reset_out;
    endproperty
    a_wdt_trigger: assert property (p_wdt_trigger) else $error("watchdog did not start timer");

    property p_suspend_exit;
        @(posedge clk_in) disable iff (rst_in)
        cpu_clock_suspend_mode_out && irq_serviced_in |=> !cpu_clock_suspend_mode_out;
    endproperty
    a_suspend_exit: assert property (p_suspend_exit) else $error("suspend not left on interrupt");

    property p_filter_restart;
        @(posedge clk_in) disable iff (rst_in)
        state == RPHC_QUALIFY && !pin_low && !internal_src |=> state == RPHC_RUN;
    endproperty
    a_filter_restart: assert property (p_filter_restart) else $error("filter did not restart");

    // Outside reset both strobes rest high so the core bus stays idle.
    property p_strobes_idle;
        @(posedge clk_in) disable iff (rst_in)
        !core_reset_out |-> data_strobe_n_out && address_strobe_n_out;
    endproperty
    a_strobes_idle: assert property (p_strobes_idle) else $error("strobes active outside reset");

    // A fetch pulse always carries the restart vector and never overlaps reset.
    property p_fetch_vector;
        @(posedge clk_in) disable iff (rst_in)
        fetch_start_out |-> !core_reset_out && fetch_addr_out == RESTART_VECTOR;
    endproperty
    a_fetch_vector: assert property (p_fetch_vector) else $error("fetch pulse without restart vector");

    // An undisturbed release phase ends in the fetch pulse after the fixed delay.
    property p_release_to_fetch;
        @(posedge clk_in) disable iff (rst_in)
        ($rose(state == RPHC_RELEASE) && !pin_low && !internal_src) ##1 (!pin_low && !internal_src) [*4]
            |-> ##1 fetch_start_out;
    endproperty
    a_release_to_fetch: assert property (p_release_to_fetch) else $error("fetch delay after release wrong");

    // A pin still held low keeps the stretcher in its hold phase.
    property p_hold_while_pin_low;
        @(posedge clk_in) disable iff (rst_in)
        state == RPHC_HOLD && pin_low |=> state == RPHC_HOLD;
    endproperty
    a_hold_while_pin_low: assert property (p_hold_while_pin_low) else $error("hold left while pin low");

    // A running power-on timer forces the hold phase from any state.
    property p_internal_forces_hold;
        @(posedge clk_in) disable iff (rst_in)
        por_active |=> state == RPHC_HOLD;
    endproperty
    a_internal_forces_hold: assert property (p_internal_forces_hold) else $error("timer did not force hold");

    // Sleep recovery with the bypass bit clear starts the power-on timer.
    property p_sleep_starts_timer;
        @(posedge clk_in) disable iff (rst_in)
        sleep_recovery_in && !sleep_ctrl_in[SLEEP_BYPASS_BIT] |=> por_active;
    endproperty
    a_sleep_starts_timer: assert property (p_sleep_starts_timer) else $error("sleep recovery missed timer");

    // With the bypass bit set and no other trigger, the timer stays idle.
    property p_sleep_bypass;
        @(posedge clk_in) disable iff (rst_in)
        sleep_recovery_in && sleep_ctrl_in[SLEEP_BYPASS_BIT] && !por_active && !supply_up
            && !watchdog_timeout_source_in |=> !por_active;
    endproperty
    a_sleep_bypass: assert property (p_sleep_bypass) else $error("bypassed sleep recovery started timer");

    // Suspend holds until an interrupt is serviced, and any reset clears it.
    property p_suspend_stays;
        @(posedge clk_in) disable iff (rst_in)
        cpu_clock_suspend_mode_out && !irq_serviced_in && !in_reset |=> cpu_clock_suspend_mode_out;
    endproperty
    a_suspend_stays: assert property (p_suspend_stays) else $error("suspend left without interrupt");
endmodule // rphc_top
`default_nettype wire

// [rphc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Reset line shared by the external reset source and the device, with the internal pull-up.
module rphc_pin_model (
    input  wire logic ext_low_in,
    input  wire logic dev_level_in,
    input  wire logic dev_oe_in,
    output logic      pin_level_out
);
    // The outside source is open-drain, so nobody ever drives the line high.
    assign pin_level_out = (ext_low_in || (dev_oe_in && !dev_level_in)) ? 1'b0 : 1'b1;
endmodule // rphc_pin_model
`default_nettype wire

// [rphc_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the reset filter, reset stretcher, pin drive and suspend control.
module rphc_top_bench;
    import rphc_pkg::*;
    localparam int TICKS = 4;
    localparam int LIMIT = 20000;
    logic clk_in = 1'b0, rst_in = 1'b1, ext_low = 1'b0, rc_tick_in = 1'b0;
    logic supply_good_in = 1'b1, watchdog_timeout_source_in = 1'b0, sleep_recovery_in = 1'b0;
    logic suspend_req_in = 1'b0, irq_serviced_in = 1'b0;
    logic [7:0] sleep_ctrl_in = 8'h00;
    logic reset_pin_in, reset_pin_out, reset_pin_oe_out, data_strobe_n_out, address_strobe_n_out;
    logic core_reset_out, fetch_start_out, cpu_clock_suspend_mode_out;
    logic [15:0] fetch_addr_out;
    int errors = 0, n_checks = 0, cycles = 0, rc_div = 0;

    rphc_top #(.POR_TICKS(TICKS)) rphc_top_inst (.clk_in(clk_in), .rst_in(rst_in),
        .reset_pin_in(reset_pin_in), .rc_tick_in(rc_tick_in), .supply_good_in(supply_good_in),
        .watchdog_timeout_source_in(watchdog_timeout_source_in), .sleep_recovery_in(sleep_recovery_in),
        .sleep_ctrl_in(sleep_ctrl_in), .suspend_req_in(suspend_req_in), .irq_serviced_in(irq_serviced_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out),
        .data_strobe_n_out(data_strobe_n_out), .address_strobe_n_out(address_strobe_n_out),
        .core_reset_out(core_reset_out), .fetch_start_out(fetch_start_out),
        .fetch_addr_out(fetch_addr_out), .cpu_clock_suspend_mode_out(cpu_clock_suspend_mode_out));
    rphc_pin_model rphc_pin_model_inst (.ext_low_in(ext_low), .dev_level_in(reset_pin_out),
        .dev_oe_in(reset_pin_oe_out), .pin_level_out(reset_pin_in));

    // Clock, a 1 MHz tick for the timer, and a ceiling on the whole run.
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        rc_div <= (rc_div == 49) ? 0 : rc_div + 1;
        rc_tick_in <= (rc_div == 49);
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge clk_in);
        #1;
    endtask

    // Waits for the internal reset to end and judges the restart that follows it.
    task automatic wait_release(input int lo, input int hi);
        int n;
        n = 0;
        while (core_reset_out === 1'b1 && n < 2000) begin
            step();
            n++;
        end
        chk(16'(n >= lo && n <= hi), 16'h0001);
        chk({15'h0, fetch_start_out}, 16'h0001);
        chk(fetch_addr_out, RESTART_VECTOR);
        step();
        chk({15'h0, fetch_start_out}, 16'h0000);
        chk({15'h0, reset_pin_oe_out}, 16'h0000);
    endtask

    task automatic t_por();
        chk({15'h0, reset_pin_oe_out & core_reset_out}, 16'h0001);
        chk({15'h0, reset_pin_out}, 16'h0000);
        wait_release(TICKS * 50 - 50, TICKS * 50 + 40);
    endtask

    // Two lows too short to qualify, split by one high sample, must leave the core alone.
    task automatic t_short();
        logic seen;
        seen = 1'b0;
        @(posedge clk_in) ext_low <= 1'b1;
        repeat (8) @(posedge clk_in);
        ext_low <= 1'b0;
        @(posedge clk_in) ext_low <= 1'b1;
        repeat (8) @(posedge clk_in);
        ext_low <= 1'b0;
        repeat (30) begin
            step();
            seen = seen | core_reset_out;
        end
        chk({15'h0, seen}, 16'h0000);
        chk({15'h0, seen}, 16'h0000);
    endtask

    // A short qualifying low, then a long one that outlasts the internal count.
    task automatic t_long();
        int n;
        logic a;
        n = 0;
        @(posedge clk_in) ext_low <= 1'b1;
        repeat (10) @(posedge clk_in);
        ext_low <= 1'b0;
        while (core_reset_out !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        chk(16'(n <= 12), 16'h0001);
        a = address_strobe_n_out;
        step();
        chk({15'h0, address_strobe_n_out}, {15'h0, ~a});
        chk({15'h0, data_strobe_n_out}, 16'h0000);
        wait_release(HOLD_CLKS + FETCH_DELAY_CLKS - 2, HOLD_CLKS + 10);
        @(posedge clk_in) ext_low <= 1'b1;
        repeat (60) @(posedge clk_in);
        ext_low <= 1'b0;
        #1;
        chk({15'h0, core_reset_out}, 16'h0001);
        wait_release(FETCH_DELAY_CLKS, 12);
    endtask

    // Supply rise, watchdog and deep-sleep recovery with the bypass bit clear all start the timer.
    task automatic t_sources();
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_in);
            sleep_ctrl_in <= 8'h00;
            if (k == 0) supply_good_in <= 1'b0;
            if (k == 1) watchdog_timeout_source_in <= 1'b1;
            if (k == 2) sleep_recovery_in <= 1'b1;
            @(posedge clk_in);
            supply_good_in <= 1'b1;
            watchdog_timeout_source_in <= 1'b0;
            sleep_recovery_in <= 1'b0;
            repeat (4) step();
            chk({15'h0, reset_pin_oe_out & core_reset_out}, 16'h0001);
            wait_release(TICKS * 50 - 60, TICKS * 50 + 40);
        end
        @(posedge clk_in);
        sleep_ctrl_in <= 8'h20;
        sleep_recovery_in <= 1'b1;
        @(posedge clk_in) sleep_recovery_in <= 1'b0;
        repeat (4) step();
        chk({14'h0, core_reset_out, reset_pin_oe_out}, 16'h0002);
        wait_release(FETCH_DELAY_CLKS, 40);
    endtask

    // Suspend holds until a serviced interrupt ends it; software flushes with the no-op opcode first.
    task automatic t_suspend();
        logic [7:0] last_op;
        last_op = NOP_OPCODE;
        @(posedge clk_in) suspend_req_in <= (last_op == NOP_OPCODE);
        @(posedge clk_in) suspend_req_in <= 1'b0;
        repeat (20) step();
        chk({15'h0, cpu_clock_suspend_mode_out}, 16'h0001);
        @(posedge clk_in) irq_serviced_in <= 1'b1;
        @(posedge clk_in) irq_serviced_in <= 1'b0;
        repeat (3) step();
        chk({15'h0, cpu_clock_suspend_mode_out}, 16'h0000);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The run holds reset for eight cycles, then works through each scenario once.
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        step();
        t_por();
        t_short();
        t_long();
        t_sources();
        t_suspend();
        close_out();
    end
endmodule // rphc_top_bench
`default_nettype wire
